/* File: src/stpg_top.sv */
// Test pattern generator, force-transmit words and register page
`timescale 1ns/1ps
`default_nettype none
module stpg_top
(
   input wire logic clk, // Core clock
   input wire logic nrst, // Synchronous reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire stpg_pkg::stpg_apb_req_t apb_req, // Address, dir, data
   output logic pready, // APB ready
   output logic pslverr, // APB error, always low
   output logic [31:0] prdata, // APB read data
   input wire stpg_pkg::stpg_byte_t mac_tx, // MAC transmit byte
   output stpg_pkg::stpg_byte_t fifo_tx, // Byte into transmit FIFO
   output stpg_pkg::stpg_word_t serdes_tx // Forced word to serializer
);
   import stpg_pkg::*;

   function automatic logic [31:0] crc_step(input logic [31:0] c,
      input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++)
      begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   ///////////////////////////////////////////////////////////////////
   logic [15:0] ctrl;
   logic [10:0] fta;
   logic [9:0] ftb;
   logic [3:0] blk;
   logic [15:0] ser2;
   stpg_state_t state;
   stpg_state_t next_state;
   logic [13:0] cnt;
   logic [13:0] next_cnt;
   logic [31:0] crc;
   logic run_q;
   logic phase;

   ///////////////////////////////////////////////////////////////////
   wire [5:0] idx = apb_req.paddr[7:2];
   wire aligned = apb_req.paddr[1:0] == 2'b00;
   // Fixed offsets hold nothing here and read zero in every block
   // fixed versus steered
   wire fixed = (idx <= IDX_FIXED_MAX) || (idx == IDX_FIXED_TOP);
   wire blk0 = blk == 4'h0;
   wire steer_ok = aligned && !fixed && blk0;
   wire hit_ctrl = steer_ok && idx == IDX_CTRL;
   wire hit_stat = steer_ok && idx == IDX_STAT;
   wire hit_fta = steer_ok && idx == IDX_FTA;
   wire hit_ftb = steer_ok && idx == IDX_FTB;
   wire hit_ser2 = steer_ok && idx == IDX_SER2;
   // Block register stays reachable so software can switch back
   wire hit_blk = aligned && idx == IDX_BLK;
   wire wr = psel && penable && apb_req.pwrite;
   wire [15:0] wd = apb_req.pwdata[15:0];

   wire sel_gen = ctrl[SEL_BIT];
   wire run = ctrl[RUN_BIT];
   wire single = ctrl[SINGLE_BIT];
   wire [5:0] size = ctrl[SIZE_LSB +: SIZE_W];
   wire [2:0] gap = ctrl[GAP_LSB +: GAP_W];
   wire ft_en = fta[FT_EN_BIT];

   ///////////////////////////////////////////////////////////////////
   // Invalid zero codes fall back to the smallest size and gap
   // size in 256-byte units
   wire [5:0] size_eff = (size == 6'h00) ? 6'h01 : size;
   wire [13:0] frame_len = {size_eff, 8'h00};
   wire [13:0] data_last = frame_len - CRC_BYTES - 14'h0001;
   // gap of 2 plus 4 per code
   wire [2:0] gap_eff = (gap == 3'b000) ? 3'b001 : gap;
   wire [4:0] gap_len = GAP_BASE + {gap_eff, 2'b00};
   wire [13:0] gap_last = {9'h000, gap_len - 5'h02};

   wire pg_start = run && !run_q && state == ST_IDLE;
   wire active = state != ST_IDLE;

   logic [2:0] gray;
   assign gray = (state == ST_PRE) ? 3'b001 :
                 (state == ST_SFD) ? 3'b011 :
                 (state == ST_DATA) ? 3'b010 :
                 (state == ST_CRC) ? 3'b110 :
                 (state == ST_GAP) ? 3'b100 :
                 (state == ST_GAP2) ? 3'b101 : 3'b000;
   wire [15:0] stat = {12'h000, active, gray};

   ///////////////////////////////////////////////////////////////////
   // framing sequence
   always_comb
   begin
      next_state = state;
      next_cnt = cnt + 14'h0001;
      unique case (state)
         ST_IDLE:
         begin
            next_cnt = 14'h0000;
            if (pg_start)
               next_state = ST_PRE;
         end
         ST_PRE:
         begin
            if (cnt == PRE_LAST)
            begin
               next_state = ST_SFD;
               next_cnt = 14'h0000;
            end
         end
         ST_SFD:
         begin
            next_state = ST_DATA;
            next_cnt = 14'h0000;
         end
         ST_DATA:
         begin
            if (cnt == data_last)
            begin
               next_state = ST_CRC;
               next_cnt = 14'h0000;
            end
         end
         ST_CRC:
         begin
            if (cnt == CRC_LAST)
            begin
               next_state = ST_GAP;
               next_cnt = 14'h0000;
            end
         end
         ST_GAP:
         begin
            if (cnt == gap_last)
            begin
               next_state = ST_GAP2;
               next_cnt = 14'h0000;
            end
         end
         ST_GAP2:
         begin
            next_cnt = 14'h0000;
            if (single || !run)
               next_state = ST_IDLE;
            else
               next_state = ST_PRE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state <= ST_IDLE;
         cnt <= 14'h0000;
         run_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         run_q <= run;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         crc <= CRC_INIT;
      else if (state == ST_SFD)
         crc <= CRC_INIT;
      else if (state == ST_DATA)
         crc <= crc_step(crc, cnt[7:0]);
   end

   ///////////////////////////////////////////////////////////////////
   // CRC goes out inverted, low byte first
   wire [31:0] crc_sh = ~crc >> {cnt[1:0], 3'b000};
   stpg_byte_t gen_byte;
   assign gen_byte.valid = state inside {ST_PRE, ST_SFD, ST_DATA, ST_CRC};
   assign gen_byte.data = (state == ST_PRE) ? PRE_BYTE :
                          (state == ST_SFD) ? SFD_BYTE :
                          (state == ST_DATA) ? cnt[7:0] :
                          (state == ST_CRC) ? crc_sh[7:0] : 8'h00;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         fifo_tx <= '0;
      else if (sel_gen)
         fifo_tx <= gen_byte;
      else
         fifo_tx <= mac_tx;
   end

   ///////////////////////////////////////////////////////////////////
   // alternate A and B each clock
   wire [9:0] force_code = phase ? ftb : fta[FT_W-1:0];

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         phase <= 1'b0;
         serdes_tx <= '0;
      end
      else
      begin
         phase <= ft_en ? !phase : 1'b0;
         serdes_tx.force_en <= ft_en;
         serdes_tx.idle_test <= ser2[IDLE_TEST_BIT];
         serdes_tx.code <= ft_en ? force_code : 10'h000;
      end
   end

   ///////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ctrl <= CTRL_RST;
         fta <= FTA_RST;
         ftb <= FTB_RST;
         blk <= BLK_RST;
         ser2 <= SER2_RST;
      end
      else if (wr)
      begin
         if (hit_ctrl)
            ctrl <= wd;
         if (hit_fta)
            fta <= wd[10:0];
         if (hit_ftb)
            ftb <= wd[9:0];
         if (hit_blk)
            blk <= wd[BLK_W-1:0];
         if (hit_ser2)
            ser2 <= wd;
      end
   end

   wire [15:0] rd16 = hit_ctrl ? ctrl :
                      hit_stat ? stat :
                      hit_fta ? {5'h00, fta} :
                      hit_ftb ? {6'h00, ftb} :
                      hit_blk ? {12'h000, blk} :
                      hit_ser2 ? ser2 : 16'h0000;

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = {16'h0000, rd16};
endmodule
`default_nettype wire

/* File: src/stpg_pkg.sv */
// Constants, types and register map of the test pattern generator
// What this block does
// - Single-pass set: send exactly one packet after start, then idle.
// - Single-pass clear: send packets back to back while run stays set.
// - Start only on run rising edge while idle; held run never restarts.
// - Clearing run in continuous mode lets the current packet finish.
// - Source select high: FIFO gets idles or packets, MAC data ignored.
// - Status bit 3 reads one while sending, zero when idle.
// - Status bits 2:0 show the state in the given Gray code.
// - Force enable bit 10 sends two alternating patterns instead of traffic.
// - Force mode presents word A and word B bits 9:0 alternately.
// - Each forced word drives every other clock; word A resets to 17Ch.
// - Force mode works together with serial control bit 13 idle test.
// - Offsets 00-0f and 1f are fixed; other offsets follow block select, except block register 3e.
// - Block field 0000 selects block 0, 0001 block 1; resets to 0.
// - Gap code 001 is 6 bytes, plus 4 per code to 30; reset 100.
// - Size field counts 256-byte units; code 111111 gives 16,128 bytes.
package stpg_pkg;
   localparam logic [5:0] IDX_SER2 = 6'h22;
   localparam logic [5:0] IDX_CTRL = 6'h34;
   localparam logic [5:0] IDX_STAT = 6'h36;
   localparam logic [5:0] IDX_FTA = 6'h3A;
   localparam logic [5:0] IDX_FTB = 6'h3C;
   localparam logic [5:0] IDX_BLK = 6'h3E;
   localparam logic [5:0] IDX_FIXED_MAX = 6'h0F;
   localparam logic [5:0] IDX_FIXED_TOP = 6'h1F;
   localparam int SEL_BIT = 0;
   localparam int RUN_BIT = 1;
   localparam int SINGLE_BIT = 2;
   localparam int SIZE_LSB = 3;
   localparam int SIZE_W = 6;
   localparam int GAP_LSB = 9;
   localparam int GAP_W = 3;
   localparam int ACT_BIT = 3;
   localparam int FT_EN_BIT = 10;
   localparam int FT_W = 10;
   localparam int IDLE_TEST_BIT = 13;
   localparam int BLK_W = 4;
   localparam logic [15:0] CTRL_RST = 16'h0820;
   localparam logic [10:0] FTA_RST = 11'h17C;
   localparam logic [9:0] FTB_RST = 10'h000;
   localparam logic [3:0] BLK_RST = 4'h0;
   localparam logic [15:0] SER2_RST = 16'h0000;
   localparam logic [7:0] PRE_BYTE = 8'h55;
   localparam logic [7:0] SFD_BYTE = 8'hD5;
   localparam logic [13:0] PRE_LAST = 14'h0006;
   localparam logic [13:0] CRC_LAST = 14'h0003;
   localparam logic [13:0] CRC_BYTES = 14'h0004;
   localparam logic [4:0] GAP_BASE = 5'h02;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

   typedef struct packed {
      logic [7:0] paddr;
      logic pwrite;
      logic [31:0] pwdata;
   } stpg_apb_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } stpg_byte_t;

   typedef struct packed {
      logic force_en;
      logic idle_test;
      logic [9:0] code;
   } stpg_word_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PRE, ST_SFD, ST_DATA, ST_CRC, ST_GAP, ST_GAP2
   } stpg_state_t;
endpackage

/* File: sim/stpg_checker.sv */
// Port assertions for the pattern generator top
`timescale 1ns/1ps
`default_nettype none
module stpg_checker
(
   input wire logic clk, // Clock
   input wire logic nrst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire stpg_pkg::stpg_apb_req_t apb_req, // Request
   input wire logic [31:0] prdata, // Read data
   input wire stpg_pkg::stpg_byte_t mac_tx, // MAC byte
   input wire stpg_pkg::stpg_byte_t fifo_tx, // FIFO byte
   input wire stpg_pkg::stpg_word_t serdes_tx // Forced word
);
   import stpg_pkg::*;
   logic sel, sel_d;
   wire gen = sel && sel_d;
   wire st_rd = psel && penable && apb_req.paddr == 8'hD8;
   wire fx = apb_req.paddr < 8'h40 || apb_req.paddr == 8'h7C;
   // Mirror of the source select bit
   always_ff @(posedge clk)
   begin
      sel_d <= sel;
      if (!nrst)
         sel <= 1'b0;
      else if (psel && penable && apb_req.pwrite && apb_req.paddr == 8'hD0)
         sel <= apb_req.pwdata[SEL_BIT];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   AST_MAC_PASS: assert property ($past(nrst) && !$past(sel)
      |-> fifo_tx == $past(mac_tx)) else $error("MAC byte lost");
   AST_PREAMBLE: assert property (gen && $rose(fifo_tx.valid)
      |-> (fifo_tx.data == PRE_BYTE) [*7] ##1 fifo_tx.data == SFD_BYTE)
      else $error("Bad frame head");
   AST_PAYLOAD: assert property (gen && fifo_tx.data == SFD_BYTE
      && $past(fifo_tx.data) == PRE_BYTE |=> fifo_tx.valid [*8])
      else $error("Payload broken");
   AST_GAP: assert property (gen && $fell(fifo_tx.valid)
      |-> !fifo_tx.valid [*6]) else $error("Gap too short");
   AST_STATUS: assert property (st_rd |-> prdata[31:4] == 28'h0
      && prdata[3] == (prdata[2:0] != 3'h0)) else $error("Bad status");
   AST_GRAY: assert property (st_rd |-> prdata[2:0] != 3'h7)
      else $error("Bad state code");
   AST_FIXED: assert property (psel && fx |-> prdata == 32'h0)
      else $error("Fixed offset not empty");
   AST_FORCE_ALT: assert property (serdes_tx.force_en [*3]
      |-> serdes_tx.code == $past(serdes_tx.code, 2))
      else $error("Forced words not alternating");
   AST_FORCE_OFF: assert property (!serdes_tx.force_en
      |-> serdes_tx.code == 10'h000) else $error("Word while off");
   CVR_FRAME: cover property (gen && $rose(fifo_tx.valid));
   CVR_FORCE: cover property ($rose(serdes_tx.force_en));
   CVR_BUSY: cover property (st_rd && prdata[3]);
endmodule
bind stpg_top stpg_checker u_chk (.clk, .nrst, .psel, .penable,
   .apb_req, .prdata, .mac_tx, .fifo_tx, .serdes_tx);
`default_nettype wire

/* File: sim/stpg_tx_sink.sv */
// Far end of the FIFO path: measures frame and gap lengths
`timescale 1ns/1ps
`default_nettype none
module stpg_tx_sink
(
   input wire logic clk, // Clock
   input wire logic nrst, // Reset
   input wire stpg_pkg::stpg_byte_t fifo_tx, // FIFO byte
   output logic [15:0] run_len, // Last frame bytes
   output logic [15:0] gap_len, // Idles before it
   output logic frame_done // Frame ended
);
   import stpg_pkg::*;
   logic [15:0] cnt, idle;
   ////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      frame_done <= nrst && !fifo_tx.valid && cnt != 16'h0;
      if (!fifo_tx.valid && cnt != 16'h0)
         run_len <= cnt;
      if (fifo_tx.valid && cnt == 16'h0)
         gap_len <= idle;
      cnt <= (nrst && fifo_tx.valid) ? cnt + 16'h1 : 16'h0;
      idle <= (nrst && !fifo_tx.valid) ? idle + 16'h1 : 16'h0;
   end
endmodule
`default_nettype wire

/* File: sim/test_serdes_test_pattern_gen.sv */
// Self-checking bench of the pattern generator block
`timescale 1ns/1ps
`default_nettype none
module test_serdes_test_pattern_gen;
   import stpg_pkg::*;
   logic clk, nrst, psel, penable, pready, pslverr, done, src;
   logic [31:0] prdata, seed;
   logic [15:0] run_len, gap_len;
   logic [9:0] wa, wb;
   logic [2:0] g;
   logic [7:0] fix[4] = '{8'h00, 8'h3C, 8'h44, 8'h7C};
   logic [63:0] reg_q[$], frm_q[$], wrd_q[$];
   int errors = 0, samples_checked = 0, cyc = 0, n;
   stpg_apb_req_t apb_req;
   stpg_byte_t mac_tx, fifo_tx;
   stpg_word_t serdes_tx;
   stpg_top uut (.clk, .nrst, .psel, .penable, .apb_req, .pready,
      .pslverr, .prdata, .mac_tx, .fifo_tx, .serdes_tx);
   stpg_tx_sink sink (.clk, .nrst, .fifo_tx, .run_len, .gap_len,
      .frame_done(done));
   ////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic conclude;
      // Expectations never consumed count as a mismatch
      if (reg_q.size() + frm_q.size() + wrd_q.size() > 0)
         errors++;
      $display("Checks %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, ref logic [63:0] q[$]);
      logic [63:0] e;
      e = q.size() > 0 ? q.pop_front() : {32'hFFFFFFFF, 32'hX};
      samples_checked++;
      if ((got & e[63:32]) !== e[31:0])
      begin
         errors++;
         $display("Error at %0t: %h, expected %h", $time, got, e[31:0]);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      apb_req <= '{a, w, d};
      psel <= 1'b1;
      @(posedge clk) penable <= 1'b1;
      do
         @(posedge clk);
      while (!pready);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] m, e);
      reg_q.push_back({m, e});
      apb(a, 1'b0, 32'h0);
   endtask
   task automatic wait_q(input int k);
      for (n = 0; n < 9000 && frm_q.size() > k; n++)
         @(posedge clk);
      repeat (40) @(posedge clk);
   endtask
   always @(posedge clk)
   begin
      mac_tx <= 9'($random(seed));
      if (++cyc == 20000)
      begin
         errors++;
         conclude();
      end
      if (psel && penable && !apb_req.pwrite)
         check(prdata, reg_q);
      if (done && src)
         check({gap_len, run_len}, frm_q);
      if (serdes_tx.force_en && wrd_q.size() > 0)
         check({21'h0, serdes_tx.idle_test, serdes_tx.code}, wrd_q);
   end
   initial
   begin
      seed = 32'hFE1841AB;
      {nrst, psel, penable, src} = 4'h0;
      apb_req = '0;
      mac_tx = '0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdx(8'hD0, 32'hFFFF, 32'h0820);
      rdx(8'hD8, 32'hFFFF, 32'h0000);
      rdx(8'hE8, 32'hFFFF, 32'h017C);
      rdx(8'hF8, 32'hFFFF, 32'h0000);
      foreach (fix[i])
      begin
         apb(fix[i], 1'b1, $random(seed));
         rdx(fix[i], 32'hFFFFFFFF, 32'h0);
      end
      wa = 10'($random(seed));
      wb = 10'($random(seed));
      apb(8'hF0, 1'b1, {22'h0, wb});
      apb(8'hF8, 1'b1, 32'h1);
      rdx(8'hF0, 32'hFFFF, 32'h0);
      apb(8'hF8, 1'b1, 32'h0);
      rdx(8'hF0, 32'h3FF, {22'h0, wb});
      apb(8'hE8, 1'b1, {22'h0, wa});
      apb(8'h88, 1'b1, 32'h2000);
      repeat (2)
      begin
         wrd_q.push_back({32'h7FF, 22'h1, wa});
         wrd_q.push_back({32'h7FF, 22'h1, wb});
      end
      apb(8'hE8, 1'b1, {21'h0, 1'b1, wa});
      repeat (8) @(posedge clk);
      apb(8'hE8, 1'b1, {22'h0, wa});
      apb(8'h88, 1'b1, 32'h0);
      apb(8'hD0, 1'b1, 32'h0201);
      repeat (4) @(posedge clk);
      src <= 1'b1;
      frm_q.push_back({32'hFFFF, 32'h0108});
      apb(8'hD0, 1'b1, 32'h020F);
      wait_q(0);
      rdx(8'hD8, 32'hF, 32'h0);
      repeat (600) @(posedge clk);
      rdx(8'hD8, 32'hF, 32'h0);
      g = 3'h1 + 3'($unsigned($random(seed)) % 7);
      apb(8'hD0, 1'b1, {20'h0, g, 9'h009});
      frm_q.push_back({32'hFFFF, 32'h0108});
      repeat (2) frm_q.push_back({32'hFFFFFFFF, 16'(2 + 4 * g), 16'h0108});
      apb(8'hD0, 1'b1, {20'h0, g, 9'h00B});
      wait_q(1);
      rdx(8'hD8, 32'h8, 32'h8);
      apb(8'hD0, 1'b1, {20'h0, g, 9'h009});
      wait_q(0);
      repeat (600) @(posedge clk);
      rdx(8'hD8, 32'hF, 32'h0);
      src <= 1'b0;
      apb(8'hD0, 1'b1, 32'h0);
      repeat (50) @(posedge clk);
      conclude();
   end
endmodule
`default_nettype wire
